// ---- shared/ampsg_pkg.sv ----
// Purpose: shared constants for the amplifier serial gain/mode control link
// Assumes: core_clk at 40 MHz on both ends
// Notes:   word layout, power-up settings, apb map of the host controller
package ampsg_pkg;
  localparam int WORD_BITS      = 8;
  localparam int MODE_LSB       = 0;
  localparam int MODE_W         = 3;
  localparam int GAIN_LSB       = 3;
  localparam int GAIN_W         = 5;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [4:0] GAIN_RESET = 5'h1B;
  localparam logic [3:0] CNT_RESET  = 4'h0;
  // gain in tenths of a dB: -345 + 15 * code
  localparam int GAIN_MIN_TENTHS_DB  = -345;
  localparam int GAIN_STEP_TENTHS_DB = 15;
  // link clock limit and core clock
  localparam int CORE_CLK_MHZ   = 40;
  localparam int LINK_MAX_MHZ   = 10;
  localparam int HALF_PERIOD_CYC = (CORE_CLK_MHZ + 2 * LINK_MAX_MHZ - 1) / (2 * LINK_MAX_MHZ);
  localparam logic [7:0] DIV_RESET = 8'h04;
  // host apb register map
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_DIV    = 12'h008;
  localparam logic [11:0] REG_SHADOW = 12'h00C;
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_LEAD  = 2'b01,
    HS_SHIFT = 2'b10,
    HS_TAIL  = 2'b11
  } ampsg_hstate_t;
  typedef enum logic [1:0] {
    RT_OFF   = 2'b00,
    RT_PHONE = 2'b01,
    RT_STER  = 2'b10,
    RT_MIX   = 2'b11
  } ampsg_route_t;
endpackage

// ---- shared/ampsg_if.sv ----
// Purpose: three-wire link between host controller and amplifier control port
// Assumes: all wires driven by one end only: the host, or the bench on the fault link
// Notes:   no clocking block; both ends sample with their own core clock
`timescale 1ns/1ps
`default_nettype none
interface ampsg_if;
  logic serialData;
  logic linkClk;
  logic latchEnable;
  modport host (output serialData, output linkClk, output latchEnable);
  modport device (input serialData, input linkClk, input latchEnable);
endinterface
`default_nettype wire

// ---- rtl/ampsg_device.sv ----
// Purpose: amplifier serial control port, shifts word and applies mode/gain
// Assumes: link pins asynchronous to core_clk, link clock at most 10 MHz
// Notes:   route outputs encode which source feeds each amplifier
// Contract
// - sample data on link rising edge while enabled
// - host sends least significant bit first
// - one transfer is exactly eight bits
// - bits 0..2 select output mode
// - bits 3..7 form gain code
// - enable active high, held through transfer
// - host ends transfer by dropping enable
// - apply only when eight bits received
// - ignore activity after eighth rising edge
// - mode 000 shuts down all outputs
// - modes 001/010 phone to speaker/headsets
// - modes 011/100/101 stereo routes and sums
// - mode 110 headsets stereo plus phone
// - mode 111 speaker phone, headsets right-plus-phone
// - gain code linear, 1.5 dB steps
// - phone gain fixed, independent of code
// - power-up gain +6 dB, full standby
// - host link clock at most 10 MHz
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ampsg_device (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  // link
  ampsg_if.device          link,
  // applied settings
  output logic [2:0]       modeOut,
  output logic [4:0]       gainCode,
  output logic signed [9:0] gainTenthsDb,
  // routing: speaker source, headset sources
  output logic             speakerShutdown,
  output logic             spkPhone,
  output logic             spkStereoSum,
  output logic             headShutdown,
  output logic             headPhone,
  output logic             headStereo,
  output logic             headLeftFromRight,
  output logic             wordApplied
);
  logic [1:0] dataSync_reg, clkSync_reg, enSync_reg;
  logic       clkPrev_reg, enPrev_reg;
  logic [7:0] shift_reg;
  logic [3:0] count_reg;
  logic [2:0] mode_reg;
  logic [4:0] gain_reg;
  logic       applied_reg;

  // stage 0 feeds stage 1 only; edges judged between stage 1 and history
  wire dataS   = dataSync_reg[1];
  wire clkS    = clkSync_reg[1];
  wire enS     = enSync_reg[1];
  wire clkRise = clkS & ~clkPrev_reg;
  wire enRise  = enS & ~enPrev_reg;
  wire enFall  = ~enS & enPrev_reg;
  wire full    = (count_reg == 4'(ampsg_pkg::WORD_BITS));
  wire takeBit = enS & clkRise & ~full;
  wire apply   = enFall & full;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dataSync_reg <= 2'h0;
      clkSync_reg  <= 2'h0;
      enSync_reg   <= 2'h0;
      clkPrev_reg  <= 1'b0;
      enPrev_reg   <= 1'b0;
    end else if (clkEn) begin
      dataSync_reg <= {dataSync_reg[0], link.serialData};
      clkSync_reg  <= {clkSync_reg[0], link.linkClk};
      enSync_reg   <= {enSync_reg[0], link.latchEnable};
      clkPrev_reg  <= clkS;
      enPrev_reg   <= enS;
    end
  end

  // lsb arrives first, so shift right from the top
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= 8'h00;
      count_reg <= ampsg_pkg::CNT_RESET;
    end else if (clkEn) begin
      if (enRise) begin
        count_reg <= ampsg_pkg::CNT_RESET;
      end else if (takeBit) begin
        shift_reg <= {dataS, shift_reg[7:1]};
        count_reg <= count_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg    <= ampsg_pkg::MODE_RESET;
      gain_reg    <= ampsg_pkg::GAIN_RESET;
      applied_reg <= 1'b0;
    end else if (clkEn) begin
      applied_reg <= apply;
      if (apply) begin
        mode_reg <= shift_reg[ampsg_pkg::MODE_LSB +: ampsg_pkg::MODE_W];
        gain_reg <= shift_reg[ampsg_pkg::GAIN_LSB +: ampsg_pkg::GAIN_W];
      end
    end
  end

  assign modeOut     = mode_reg;
  assign gainCode    = gain_reg;
  assign wordApplied = applied_reg;
  assign gainTenthsDb = 10'(ampsg_pkg::GAIN_MIN_TENTHS_DB
                      + ampsg_pkg::GAIN_STEP_TENTHS_DB * int'(gain_reg));

  // phone path gain is fixed by the path itself, never by the code
  wire m0 = mode_reg[0];
  wire m1 = mode_reg[1];
  wire m2 = mode_reg[2];
  assign spkPhone        = m0 & (~m1 | m2);
  assign spkStereoSum    = m0 & m1 & ~m2 | m0 & ~m1 & m2;
  assign speakerShutdown = ~m0;
  assign headPhone       = ~m0 & m1 | m2 & m1;
  assign headStereo      = m2 & ~m0 | m2 & m1;
  assign headShutdown    = ~headPhone & ~headStereo;
  assign headLeftFromRight = (mode_reg == 3'h7);
endmodule
`default_nettype wire

// ---- rtl/ampsg_host.sv ----
// Purpose: apb-controlled host that writes one 8-bit word over the link
// Assumes: core_clk 40 MHz; divider keeps link clock at or below 10 MHz
// Notes:   link clock made here by dividing core_clk
`timescale 1ns/1ps
`default_nettype none
module ampsg_host (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  ampsg_if.host            link
);
  ampsg_pkg::ampsg_hstate_t state_reg, state_next;
  logic [7:0] word_reg, shadow_reg, div_reg, half_reg;
  logic [2:0] bit_reg;
  logic       sclk_reg, sdat_reg, en_reg, done_reg;

  wire wr      = psel & penable & pwrite;
  wire hitCtrl = (paddr == ampsg_pkg::REG_CTRL);
  wire hitStat = (paddr == ampsg_pkg::REG_STATUS);
  wire hitDiv  = (paddr == ampsg_pkg::REG_DIV);
  wire hitShad = (paddr == ampsg_pkg::REG_SHADOW);
  wire busy    = (state_reg != ampsg_pkg::HS_IDLE);
  wire start   = wr & hitCtrl & ~busy;
  wire tick    = (half_reg == 8'h00);
  wire [7:0] divSafe = (div_reg < 8'(ampsg_pkg::HALF_PERIOD_CYC))
                     ? 8'(ampsg_pkg::HALF_PERIOD_CYC) : div_reg;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(hitCtrl | hitStat | hitDiv | hitShad);
  assign prdata  = hitCtrl ? {24'h00_0000, word_reg}
                 : hitStat ? {30'h0000_0000, done_reg, busy}
                 : hitDiv  ? {24'h00_0000, div_reg}
                 : hitShad ? {24'h00_0000, shadow_reg} : 32'h0000_0000;
  assign link.serialData  = sdat_reg;
  assign link.linkClk     = sclk_reg;
  assign link.latchEnable = en_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ampsg_pkg::HS_IDLE:  if (start) state_next = ampsg_pkg::HS_LEAD;
      ampsg_pkg::HS_LEAD:  if (tick) state_next = ampsg_pkg::HS_SHIFT;
      ampsg_pkg::HS_SHIFT: if (tick && sclk_reg && bit_reg == 3'h7) state_next = ampsg_pkg::HS_TAIL;
      // second tick keeps enable low a full phase before the next frame
      ampsg_pkg::HS_TAIL:  if (tick && !en_reg) state_next = ampsg_pkg::HS_IDLE;
      default:             state_next = ampsg_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= ampsg_pkg::HS_IDLE;
      word_reg   <= 8'h00;
      shadow_reg <= {ampsg_pkg::GAIN_RESET, ampsg_pkg::MODE_RESET};
      div_reg    <= ampsg_pkg::DIV_RESET;
      half_reg   <= 8'h00;
      bit_reg    <= 3'h0;
      sclk_reg   <= 1'b0;
      sdat_reg   <= 1'b0;
      en_reg     <= 1'b0;
      done_reg   <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      half_reg  <= (tick || start) ? divSafe - 8'h01 : half_reg - 8'h01;
      if (wr && hitDiv) div_reg <= pwdata[7:0];
      // completion flag: set wins over a clear in the same cycle
      if (busy && state_next == ampsg_pkg::HS_IDLE) done_reg <= 1'b1;
      else if (wr && hitStat && pwdata[1]) done_reg <= 1'b0;
      if (start) begin
        word_reg <= pwdata[7:0];
        en_reg   <= 1'b1;
        bit_reg  <= 3'h0;
        sdat_reg <= pwdata[0];
        done_reg <= 1'b0;
      end else if (tick && state_reg == ampsg_pkg::HS_SHIFT) begin
        sclk_reg <= ~sclk_reg;
        if (sclk_reg) begin
          bit_reg  <= bit_reg + 3'h1;
          sdat_reg <= word_reg[3'(bit_reg + 3'h1)];
        end
      end else if (tick && state_reg == ampsg_pkg::HS_TAIL) begin
        en_reg     <= 1'b0;
        shadow_reg <= word_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/ampsg_properties.sv ----
// Purpose: link framing and applied-settings properties
// Assumes: both ends run on core_clk
// Notes:   watches the host-to-device link and device outputs
`timescale 1ns/1ps
`default_nettype none
module ampsg_properties (
  // clock, reset
  input wire logic       core_clk,
  input wire logic       resetn,
  // link
  input wire logic       serialData,
  input wire logic       linkClk,
  input wire logic       latchEnable,
  // device settings
  input wire logic [2:0] modeOut,
  input wire logic [4:0] gainCode,
  input wire logic       speakerShutdown,
  input wire logic       headShutdown,
  input wire logic       wordApplied
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_fall; $fell(latchEnable); endsequence
  sequence s_chg; !$stable(modeOut) || !$stable(gainCode); endsequence
  // two quiet cycles before the decode is judged
  sequence s_settled; $stable(modeOut) [*2]; endsequence
  property p_idle; !latchEnable |-> !linkClk; endproperty
  property p_gap; s_fall |=> !latchEnable [*2]; endproperty
  property p_apply; s_chg |-> wordApplied; endproperty
  property p_pulse; wordApplied |=> !wordApplied; endproperty
  property p_late; s_chg |-> !latchEnable && !$past(latchEnable, 3); endproperty
  property p_sd0; s_settled ##0 (modeOut == 3'h0) |-> speakerShutdown && headShutdown; endproperty
  property p_spk; s_settled |-> speakerShutdown == !modeOut[0]; endproperty
  property p_head;
    s_settled |-> headShutdown == (modeOut inside {3'h0, 3'h1, 3'h3, 3'h5});
  endproperty
  a_idle: assert property (p_idle) else $error("link clock moved outside frame");
  a_gap: assert property (p_gap) else $error("enable low too short");
  a_apply: assert property (p_apply) else $error("settings changed without pulse");
  a_pulse: assert property (p_pulse) else $error("apply pulse too long");
  a_late: assert property (p_late) else $error("settings changed inside frame");
  a_sd0: assert property (p_sd0) else $error("mode zero not standby");
  a_spk: assert property (p_spk) else $error("speaker decode wrong");
  a_head: assert property (p_head) else $error("headset decode wrong");
endmodule
`default_nettype wire

// ---- sim/amp_serial_mode_gain_control_bench.sv ----
// Purpose: host and device joined, driven over apb; fault link on a second device
// Assumes: pready answers in access phase
// Notes:   second link is bench-driven to send short and long frames
`timescale 1ns/1ps
`default_nettype none
module amp_serial_mode_gain_control_bench;
  // rt: speaker phone, speaker sum, headset phone, headset stereo, left from right
  typedef struct packed {logic [7:0] w; logic spk; logic hd; logic [4:0] rt;} ampsg_row_t;
  ampsg_row_t  rows [8] = '{'{8'h00,1,1,5'h00}, '{8'h09,0,1,5'h10}, '{8'hFA,1,0,5'h04},
                           '{8'h53,0,1,5'h08}, '{8'hBC,1,0,5'h02}, '{8'h2D,0,1,5'h18},
                           '{8'h76,1,0,5'h06}, '{8'hFF,0,0,5'h17}};
  logic        core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, wordApplied, spkSd, headSd;
  logic        spkPh, spkSum, hdPh, hdSt, hdR, faultEn = 1;
  logic [2:0]  modeOut, m2;
  logic [4:0]  gainCode, g2;
  logic signed [9:0] gainDb;
  int          fails = 0, comparisons = 0, k;
  ampsg_if link();
  ampsg_if link2();
  ampsg_host ampsg_host_inst (.core_clk(core_clk), .resetn(resetn), .clkEn(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  ampsg_device ampsg_device_inst (.core_clk(core_clk), .resetn(resetn), .clkEn(1'b1),
    .link(link), .modeOut(modeOut), .gainCode(gainCode), .gainTenthsDb(gainDb),
    .speakerShutdown(spkSd), .spkPhone(spkPh), .spkStereoSum(spkSum), .headShutdown(headSd),
    .headPhone(hdPh), .headStereo(hdSt), .headLeftFromRight(hdR), .wordApplied(wordApplied));
  // fault end: bench breaks the frame length on purpose
  ampsg_device ampsg_device_fault_inst (.core_clk(core_clk), .resetn(resetn), .clkEn(faultEn),
    .link(link2), .modeOut(m2), .gainCode(g2), .gainTenthsDb(), .speakerShutdown(),
    .spkPhone(), .spkStereoSum(), .headShutdown(), .headPhone(), .headStereo(),
    .headLeftFromRight(), .wordApplied());
  ampsg_properties ampsg_properties_inst (.core_clk(core_clk), .resetn(resetn),
    .serialData(link.serialData), .linkClk(link.linkClk), .latchEnable(link.latchEnable),
    .modeOut(modeOut), .gainCode(gainCode), .speakerShutdown(spkSd),
    .headShutdown(headSd), .wordApplied(wordApplied));
  always #12.5 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // entered just after a rising edge; answer taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk) penable <= 1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  // link phases of 4 core cycles give a 200 ns link period
  task automatic frame(input logic [15:0] w, input int n);
    link2.latchEnable <= 1;
    for (int i = 0; i < n; i++) begin
      link2.serialData <= w[i];
      repeat (4) @(posedge core_clk);
      link2.linkClk <= 1;
      repeat (4) @(posedge core_clk);
      link2.linkClk <= 0;
    end
    repeat (4) @(posedge core_clk);
    link2.latchEnable <= 0;
    link2.serialData <= ~w[n-1];
    repeat (10) @(posedge core_clk);
  endtask
  initial begin
    link2.latchEnable = 0;
    link2.linkClk = 0;
    link2.serialData = 0;
    repeat (6) @(posedge core_clk);
    resetn <= 1;
    @(posedge core_clk);
    check(gainCode, ampsg_pkg::GAIN_RESET);
    check(modeOut, 32'h0000_0000);
    apb(0, ampsg_pkg::REG_SHADOW, 0);
    check(rd, {24'h00_0000, ampsg_pkg::GAIN_RESET, ampsg_pkg::MODE_RESET});
    apb(0, 12'h010, 0);
    check(err, 1'b1);
    apb(1, ampsg_pkg::REG_DIV, 32'h0000_0002); // fastest legal link clock
    apb(0, ampsg_pkg::REG_DIV, 0);
    check(rd, 32'h0000_0002);
    foreach (rows[i]) begin
      apb(1, ampsg_pkg::REG_CTRL, {24'h0, rows[i].w});
      apb(1, ampsg_pkg::REG_CTRL, 32'h0000_0055); // ignored while busy
      apb(0, ampsg_pkg::REG_STATUS, 0);
      check(rd[0], 1'b1);
      k = 0;
      do begin
        apb(0, ampsg_pkg::REG_STATUS, 0);
        k++;
      end while (rd[1] !== 1'b1 && k < 200);
      check(rd[1], 1'b1);
      repeat (6) @(posedge core_clk);
      check(modeOut, rows[i].w[2:0]);
      check(gainCode, rows[i].w[7:3]);
      check(gainDb, -345 + 15 * int'(rows[i].w[7:3]));
      check(spkSd, rows[i].spk);
      check(headSd, rows[i].hd);
      check({spkPh, spkSum, hdPh, hdSt, hdR}, rows[i].rt);
      apb(0, ampsg_pkg::REG_SHADOW, 0);
      check(rd, {24'h0, rows[i].w});
      apb(1, ampsg_pkg::REG_STATUS, 32'h0000_0002);
      $display("row %0d done", i);
    end
    frame(16'h00B5, 5);
    check({m2, g2}, {3'h0, ampsg_pkg::GAIN_RESET});
    frame(16'h03A6, 10);
    check({m2, g2}, {3'h6, 5'h14});
    frame(16'h0059, 8);
    check({m2, g2}, {3'h1, 5'h0B});
    // frozen end must not see a whole frame
    faultEn <= 0;
    frame(16'h00FF, 8);
    check({m2, g2}, {3'h1, 5'h0B});
    faultEn <= 1;
    $display("fault link done");
    resetn <= 0;
    repeat (2) @(posedge core_clk);
    check({modeOut, gainCode}, {ampsg_pkg::MODE_RESET, ampsg_pkg::GAIN_RESET});
    check({m2, g2}, {ampsg_pkg::MODE_RESET, ampsg_pkg::GAIN_RESET});
    resetn <= 1;
    @(posedge core_clk);
    apb(0, ampsg_pkg::REG_SHADOW, 0);
    check(rd, {24'h00_0000, ampsg_pkg::GAIN_RESET, ampsg_pkg::MODE_RESET});
    $display("reset test done");
    close_out();
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
